// File: src/irc_map.vh
`ifndef IRC_MAP_VH
`define IRC_MAP_VH
// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define IRC_IDX_ACK 10'h000
`define IRC_IDX_CTL_BASE 10'h055
`define IRC_IDX_CTL_LAST 10'h05c
`define IRC_IDX_PORT8 10'h010
`define IRC_IDX_CLKCTL 10'h011
`define IRC_IDX_SRCSEL 10'h012
`define IRC_IDX_USP 10'h020
`define IRC_IDX_ISP 10'h021
`define IRC_IDX_STAT 10'h030
`define IRC_IDX_MASK 10'h031
// ****************************************
// Field positions
// ****************************************
`define IRC_CTL_LVL_HI 2
`define IRC_CTL_FLAG 3
`define IRC_CTL_POL 4
`define IRC_PORT8_NMI 5
`define IRC_CLK_STOP 0
`define IRC_CLK_WAIT 1
`define IRC_SRC_SWAP 0
`define IRC_ST_NMI 0
`define IRC_ST_REQ 1
`define IRC_ST_PRGACK 2
// ****************************************
// Sizes and reset values
// ****************************************
`define IRC_NSRC 8
`define IRC_NPER 6
`define IRC_NST 3
`define IRC_SP_RST 16'h0000
// Edge detector idle state: both pins high, peripherals low
`define IRC_EFF_IDLE 8'hc0
`define IRC_RESP_OKAY 2'b00
`define IRC_RESP_SLVERR 2'b10
`endif

// File: src/irc_resolve.v
`timescale 1ns/1ps
`default_nettype none
`include "irc_map.vh"
module irc_resolve (
    // Request state
    input wire [`IRC_NSRC-1:0] flags,
    input wire [3*`IRC_NSRC-1:0] levels,
    // Winner
    output wire found,
    output wire [2:0] win_num,
    output wire [2:0] win_lvl
);
    wire [3*(`IRC_NSRC+1)-1:0] best_lvl;
    wire [3*(`IRC_NSRC+1)-1:0] best_num;
    assign best_lvl[2:0] = 3'h0;
    assign best_num[2:0] = 3'h0;
    // Level zero means disabled; ties go to the lower number
    genvar k;
    generate
        for (k = 0; k < `IRC_NSRC; k = k + 1) begin : g_chain
            localparam [2:0] SRC_NUM = k;
            wire [2:0] lv = levels[3*k+2:3*k];
            wire take = flags[k] && (lv > best_lvl[3*k+2:3*k]);
            assign best_lvl[3*k+5:3*k+3] = take ? lv : best_lvl[3*k+2:3*k];
            assign best_num[3*k+5:3*k+3] = take ? SRC_NUM : best_num[3*k+2:3*k];
        end
    endgenerate
    assign win_lvl = best_lvl[3*`IRC_NSRC+2:3*`IRC_NSRC];
    assign win_num = best_num[3*`IRC_NSRC+2:3*`IRC_NSRC];
    assign found = (win_lvl != 3'h0);
endmodule // irc_resolve
`default_nettype wire

// File: src/irc_sync.v
`timescale 1ns/1ps
`default_nettype none
module irc_sync #(
    parameter W = 3
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Levels
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    // Idle level of the pins is high
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= {W{1'b1}};
            stage2 <= {W{1'b1}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end
    assign sync_out = stage2;
endmodule // irc_sync
`default_nettype wire

// File: src/irc_top.v
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "irc_map.vh"
module irc_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Request sources
    input wire [`IRC_NPER-1:0] periph_req,
    input wire ext_pin0,
    input wire ext_pin5,
    input wire nmi_n,
    // CPU core
    input wire [2:0] cpu_ipl,
    input wire cpu_instr_done,
    input wire cpu_ack,
    input wire cpu_nmi_ack,
    output reg cpu_irq,
    output reg cpu_nmi,
    output reg cpu_ack_valid,
    output reg [5:0] cpu_ack_data,
    output reg cpu_halt,
    output reg cpu_clk_run,
    output reg stop_clocks,
    output reg [15:0] user_stack_pointer,
    output reg [15:0] interrupt_stack_pointer,
    // Interrupt
    output reg irq
);
    // ****************************************
    // Decoding
    // ****************************************
    function is_ctl;
        input [9:0] idx;
        begin
            is_ctl = (idx >= `IRC_IDX_CTL_BASE) && (idx <= `IRC_IDX_CTL_LAST);
        end
    endfunction
    // ****************************************
    // Pin synchronisers and request state
    // ****************************************
    wire [2:0] pins_s;
    wire nmi_lvl = pins_s[2];
    irc_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({nmi_n, ext_pin5, ext_pin0}),
        .sync_out(pins_s)
    );
    reg [3*`IRC_NSRC-1:0] level_vec;
    reg [`IRC_NSRC-1:0] pol_vec;
    reg [`IRC_NSRC-1:0] request_pending_flag;
    reg [`IRC_NSRC-1:0] prev_eff;
    reg [7:0] ext_irq_source_select;
    reg nmi_prev;
    reg nmi_pend;
    reg first_instr;
    reg all_clocks_stop_bit;
    reg wait_bit;
    reg nmi_halt;
    reg [`IRC_NST-1:0] irq_status;
    reg [`IRC_NST-1:0] irq_mask;
    wire swap = ext_irq_source_select[`IRC_SRC_SWAP];
    wire [`IRC_NSRC-1:0] src_lvl = {swap ? pins_s[0] : pins_s[1], swap ? pins_s[1] : pins_s[0], periph_req};
    // Polarity and source changes reach the edge detector directly
    wire [`IRC_NSRC-1:0] eff = src_lvl ^ pol_vec;
    wire [`IRC_NSRC-1:0] rise = eff & ~prev_eff;
    wire nmi_fall = nmi_prev & ~nmi_lvl;
    wire found;
    wire [2:0] win_num;
    wire [2:0] win_lvl;
    irc_resolve u_res (
        .flags(request_pending_flag),
        .levels(level_vec),
        .found(found),
        .win_num(win_num),
        .win_lvl(win_lvl)
    );
    // ****************************************
    // AXI4-Lite handshakes
    // ****************************************
    reg [9:0] wr_idx;
    reg aw_got;
    reg w_got;
    reg [31:0] wd;
    reg [3:0] ws;
    wire do_wr = aw_got && w_got && !s_axi_bvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [9:0] rd_idx = s_axi_araddr[11:2];
    wire prg_ack = ar_take && (rd_idx == `IRC_IDX_ACK);
    wire ack_clr = (prg_ack || cpu_ack) && found;
    wire wr_b0 = do_wr && ws[0];
    wire wr_ctl = wr_b0 && is_ctl(wr_idx);
    wire [9:0] wr_off = wr_idx - `IRC_IDX_CTL_BASE;
    wire [2:0] wr_sel = wr_off[2:0];
    wire wr_ok = (wr_idx == `IRC_IDX_CLKCTL) || (wr_idx == `IRC_IDX_SRCSEL) || (wr_idx == `IRC_IDX_USP)
        || (wr_idx == `IRC_IDX_ISP) || (wr_idx == `IRC_IDX_STAT) || (wr_idx == `IRC_IDX_MASK) || is_ctl(wr_idx);
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IRC_RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_idx <= 10'h000;
            wd <= 32'h0000_0000;
            ws <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_got <= 1'b1;
                wr_idx <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_got <= 1'b1;
                wd <= s_axi_wdata;
                ws <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `IRC_RESP_OKAY : `IRC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // ****************************************
    // Read path
    // ****************************************
    reg [31:0] rmux;
    reg rerr;
    integer r;
    always @* begin
        rmux = 32'h0000_0000;
        rerr = 1'b0;
        r = 0;
        if (is_ctl(rd_idx)) begin
            r = rd_idx - `IRC_IDX_CTL_BASE;
            rmux[`IRC_CTL_LVL_HI:0] = level_vec[3*r +: 3];
            rmux[`IRC_CTL_FLAG] = request_pending_flag[r];
            rmux[`IRC_CTL_POL] = pol_vec[r];
        end else begin
            case (rd_idx)
                `IRC_IDX_ACK: rmux[5:0] = {win_lvl, win_num};
                `IRC_IDX_PORT8: rmux[`IRC_PORT8_NMI] = nmi_lvl;
                `IRC_IDX_CLKCTL: rmux[1:0] = {wait_bit, all_clocks_stop_bit};
                `IRC_IDX_SRCSEL: rmux[7:0] = ext_irq_source_select;
                `IRC_IDX_USP: rmux[15:0] = user_stack_pointer;
                `IRC_IDX_ISP: rmux[15:0] = interrupt_stack_pointer;
                `IRC_IDX_STAT: rmux[`IRC_NST-1:0] = irq_status;
                `IRC_IDX_MASK: rmux[`IRC_NST-1:0] = irq_mask;
                default: rerr = 1'b1;
            endcase
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IRC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rmux;
                s_axi_rresp <= rerr ? `IRC_RESP_SLVERR : `IRC_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // Request flags and control fields
    // ****************************************
    reg [`IRC_NSRC-1:0] next_flag;
    integer i;
    always @* begin
        next_flag = request_pending_flag;
        for (i = 0; i < `IRC_NSRC; i = i + 1) begin
            if (wr_ctl && (wr_sel == i) && !wd[`IRC_CTL_FLAG])
                next_flag[i] = 1'b0;
            if (ack_clr && (win_num == i))
                next_flag[i] = 1'b0;
            // A fresh edge beats any clear in the same cycle
            if (rise[i])
                next_flag[i] = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            level_vec <= {3*`IRC_NSRC{1'b0}};
            pol_vec <= {`IRC_NSRC{1'b0}};
            request_pending_flag <= {`IRC_NSRC{1'b0}};
            prev_eff <= `IRC_EFF_IDLE; // Idle pins high: no false edge at release
            ext_irq_source_select <= 8'h00;
            user_stack_pointer <= `IRC_SP_RST;
            interrupt_stack_pointer <= `IRC_SP_RST;
        end else begin
            prev_eff <= eff;
            request_pending_flag <= next_flag;
            if (wr_ctl) begin
                level_vec[3*wr_sel +: 3] <= wd[`IRC_CTL_LVL_HI:0];
                pol_vec[wr_sel] <= wd[`IRC_CTL_POL];
            end
            if (wr_b0 && (wr_idx == `IRC_IDX_SRCSEL))
                ext_irq_source_select <= wd[7:0];
            if (do_wr && (wr_idx == `IRC_IDX_USP)) begin
                if (ws[0]) user_stack_pointer[7:0] <= wd[7:0];
                if (ws[1]) user_stack_pointer[15:8] <= wd[15:8];
            end
            if (do_wr && (wr_idx == `IRC_IDX_ISP)) begin
                if (ws[0]) interrupt_stack_pointer[7:0] <= wd[7:0];
                if (ws[1]) interrupt_stack_pointer[15:8] <= wd[15:8];
            end
        end
    end

    // ****************************************
    // Pin interrupt, CPU side and power modes
    // ****************************************
    wire new_req = |rise;
    always @(posedge aclk) begin
        if (!aresetn) begin
            nmi_prev <= 1'b1;
            nmi_pend <= 1'b0;
            first_instr <= 1'b1;
            all_clocks_stop_bit <= 1'b0;
            wait_bit <= 1'b0;
            nmi_halt <= 1'b0;
            cpu_irq <= 1'b0;
            cpu_nmi <= 1'b0;
            cpu_ack_valid <= 1'b0;
            cpu_ack_data <= 6'h00;
            cpu_halt <= 1'b0;
            cpu_clk_run <= 1'b1;
            stop_clocks <= 1'b0;
        end else begin
            nmi_prev <= nmi_lvl;
            // No enable term: the pin interrupt cannot be masked
            if (nmi_fall)
                nmi_pend <= 1'b1;
            else if (cpu_nmi_ack)
                nmi_pend <= 1'b0;
            if (cpu_instr_done)
                first_instr <= 1'b0;
            cpu_irq <= found && (win_lvl > cpu_ipl) && !first_instr && !cpu_ack;
            cpu_nmi <= nmi_pend && !cpu_nmi_ack && !first_instr;
            cpu_ack_valid <= cpu_ack;
            if (cpu_ack)
                cpu_ack_data <= {win_lvl, win_num};
            if (wr_b0 && (wr_idx == `IRC_IDX_CLKCTL)) begin
                all_clocks_stop_bit <= wd[`IRC_CLK_STOP];
                wait_bit <= wd[`IRC_CLK_WAIT];
            end
            if (new_req || nmi_fall)
                all_clocks_stop_bit <= 1'b0;
            // Low pin pins the stop bit, so stop mode is unreachable while the pin is low
            if (!nmi_lvl)
                all_clocks_stop_bit <= 1'b0;
            // Halted with clock running costs power until a later request
            if (new_req) begin
                wait_bit <= 1'b0;
                nmi_halt <= 1'b0;
            end
            if (nmi_fall && (wait_bit || nmi_halt))
                nmi_halt <= 1'b1;
            cpu_halt <= wait_bit || nmi_halt;
            cpu_clk_run <= !(wait_bit && !nmi_halt);
            stop_clocks <= all_clocks_stop_bit && nmi_lvl;
        end
    end
    // ****************************************
    // Event status and interrupt output
    // ****************************************
    wire [`IRC_NST-1:0] ev = {prg_ack, new_req, nmi_fall};
    wire [`IRC_NST-1:0] w1c = (do_wr && ws[0] && (wr_idx == `IRC_IDX_STAT)) ? wd[`IRC_NST-1:0] : {`IRC_NST{1'b0}};
    wire [`IRC_NST-1:0] next_status = ev | (irq_status & ~w1c);
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= {`IRC_NST{1'b0}};
            irq_mask <= {`IRC_NST{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_status <= next_status;
            if (wr_b0 && (wr_idx == `IRC_IDX_MASK))
                irq_mask <= wd[`IRC_NST-1:0];
            irq <= |(next_status & irq_mask);
        end
    end
endmodule // irc_top
`default_nettype wire

// File: testbench/interrupt_request_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irc_map.vh"
module interrupt_request_control_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [5:0] periph_req = 6'h00;
    logic ext_pin0 = 1'b0, run = 1'b0, ack_en = 1'b0;
    logic nmi_n = 1'b1;
    logic [2:0] cpu_ipl = 3'h0, lv;
    logic [1:0] ack_gap = 2'h0;
    logic [15:0] sp;
    wire awready, wready, bvalid, arready, rvalid, cpu_irq, cpu_nmi, cpu_ack_valid, cpu_halt, cpu_clk_run;
    wire stop_clocks, irq, instr_done, cpu_ack, nmi_ack;
    wire [1:0] rresp, bresp;
    wire [31:0] rdata;
    wire [5:0] cpu_ack_data;
    logic [33:0] exp_rd[$];
    logic [5:0] exp_ack[$];
    logic [1:0] exp_b[$];
    int failures = 0;
    int cmp_count = 0;
    always #20 aclk = ~aclk;
    irc_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .periph_req(periph_req), .ext_pin0(ext_pin0), .ext_pin5(1'b0), .nmi_n(nmi_n),
        .cpu_ipl(cpu_ipl), .cpu_instr_done(instr_done), .cpu_ack(cpu_ack), .cpu_nmi_ack(nmi_ack), .cpu_irq(cpu_irq),
        .cpu_nmi(cpu_nmi), .cpu_ack_valid(cpu_ack_valid), .cpu_ack_data(cpu_ack_data), .cpu_halt(cpu_halt),
        .cpu_clk_run(cpu_clk_run), .stop_clocks(stop_clocks), .user_stack_pointer(), .interrupt_stack_pointer(),
        .irq(irq)
    );
    irc_cpu_model u_cpu (
        .aclk(aclk), .aresetn(aresetn), .run(run), .ack_en(ack_en), .ack_gap(ack_gap), .cpu_irq(cpu_irq),
        .cpu_nmi(cpu_nmi), .cpu_ack_valid(cpu_ack_valid), .cpu_instr_done(instr_done), .cpu_ack(cpu_ack),
        .cpu_nmi_ack(nmi_ack)
    );
    // ****************************************
    // Compare, bus and closing tasks
    // ****************************************
    task automatic cmp_word(input string what, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_ack(input logic [5:0] e, input logic [5:0] g);
        cmp_word("cpu_ack_data", {28'h0, e}, {28'h0, g});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] eb = `IRC_RESP_OKAY);
        exp_b.push_back(eb);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] idx, input logic [33:0] e);
        exp_rd.push_back(e);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Results are matched against the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready) cmp_word("read", exp_rd.pop_front(), {rresp, rdata});
        if (cpu_ack_valid === 1'b1) cmp_ack(exp_ack.pop_front(), cpu_ack_data);
        if (bvalid && bready) cmp_word("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        conclude();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(32'h689c));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IRC_IDX_USP, 34'h0);
        rd(`IRC_IDX_ISP, 34'h0);
        sp = 16'($urandom);
        wr(`IRC_IDX_ISP, {16'h0, sp});
        rd(`IRC_IDX_ISP, {18'h0, sp});
        done("stack");
        cpu_ipl <= 3'h2;
        wr(`IRC_IDX_CTL_BASE, 32'h3);
        ack_en <= 1'b1;
        periph_req[0] <= 1'b1;
        nmi_n <= 1'b0;
        exp_ack.push_back({3'h3, 3'h0});
        idle(12);
        cmp_word("core requests", 34'h0, {32'h0, cpu_irq, cpu_nmi});
        run <= 1'b1;
        idle(20);
        nmi_n <= 1'b1;
        rd(`IRC_IDX_CTL_BASE, 34'h3);
        rd(`IRC_IDX_STAT, 34'h3);
        wr(`IRC_IDX_MASK, 32'h7);
        @(negedge aclk);
        cmp_word("irq", 34'h1, {33'h0, irq});
        wr(`IRC_IDX_STAT, 32'h7);
        @(negedge aclk);
        cmp_word("irq", 34'h0, {33'h0, irq});
        done("lockout and ack");
        ack_en <= 1'b0;
        lv = 3'(1 + $urandom % 6);
        wr(`IRC_IDX_CTL_BASE + 10'h1, {29'h0, lv});
        wr(`IRC_IDX_CTL_BASE + 10'h2, 32'h7);
        periph_req[2:1] <= 2'b11;
        idle(4);
        rd(`IRC_IDX_ACK, {28'h0, 3'h7, 3'h2});
        rd(`IRC_IDX_ACK, {28'h0, lv, 3'h1});
        rd(`IRC_IDX_ACK, 34'h0);
        rd(`IRC_IDX_CTL_BASE + 10'h2, 34'h7);
        done("program read");
        wr(`IRC_IDX_CTL_LAST, 32'h10);
        rd(`IRC_IDX_CTL_LAST, 34'h18);
        wr(`IRC_IDX_CTL_LAST, 32'h0);
        rd(`IRC_IDX_CTL_LAST, 34'h0);
        ext_pin0 <= 1'b1;
        idle(6);
        wr(`IRC_IDX_SRCSEL, 32'h1);
        rd(`IRC_IDX_CTL_LAST, 34'h8);
        done("factor change");
        fork
            wr(`IRC_IDX_CTL_BASE + 10'h3, 32'h1);
            begin
                idle(2);
                periph_req[3] <= 1'b1;
            end
        join
        rd(`IRC_IDX_CTL_BASE + 10'h3, 34'h9);
        ack_gap <= 2'($urandom);
        exp_ack.push_back({3'h1, 3'h3});
        idle(2);
        ack_en <= 1'b1;
        cpu_ipl <= 3'h0;
        idle(12);
        done("request during write");
        rd(`IRC_IDX_PORT8, 34'h20);
        nmi_n <= 1'b0;
        idle(6);
        rd(`IRC_IDX_PORT8, 34'h0);
        wr(`IRC_IDX_CLKCTL, 32'h1);
        rd(`IRC_IDX_CLKCTL, 34'h0);
        nmi_n <= 1'b1;
        idle(6);
        wr(`IRC_IDX_CLKCTL, 32'h1);
        idle(2);
        cmp_word("stop_clocks", 34'h1, {33'h0, stop_clocks});
        done("pin level and stop");
        wr(`IRC_IDX_CLKCTL, 32'h2);
        idle(2);
        cmp_word("halt run", 34'h2, {32'h0, cpu_halt, cpu_clk_run});
        nmi_n <= 1'b0;
        idle(8);
        cmp_word("halt run", 34'h3, {32'h0, cpu_halt, cpu_clk_run});
        periph_req[4] <= 1'b1;
        idle(4);
        cmp_word("halt run", 34'h1, {32'h0, cpu_halt, cpu_clk_run});
        nmi_n <= 1'b1;
        periph_req <= 6'h00;
        done("wait mode");
        wr(10'h3ff, 32'hffff_ffff, `IRC_RESP_SLVERR);
        rd(10'h3ff, {`IRC_RESP_SLVERR, 32'h0});
        aresetn <= 1'b0;
        idle(4);
        aresetn <= 1'b1;
        rd(`IRC_IDX_ISP, 34'h0);
        idle(4);
        cmp_word("acks left", 34'h0, 34'(exp_ack.size()));
        done("unmapped and reset");
        conclude();
    end
endmodule // interrupt_request_control_tb
`default_nettype wire

// File: testbench/irc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Core model: retires instructions, takes requests
// ****************************************
module irc_cpu_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench controls
    input wire logic run,
    input wire logic ack_en,
    input wire logic [1:0] ack_gap,
    // Controller side
    input wire logic cpu_irq,
    input wire logic cpu_nmi,
    input wire logic cpu_ack_valid,
    output logic cpu_instr_done,
    output logic cpu_ack,
    output logic cpu_nmi_ack
);
    logic busy;
    logic [1:0] gap_cnt;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_instr_done <= 1'b0;
            cpu_ack <= 1'b0;
            cpu_nmi_ack <= 1'b0;
            busy <= 1'b0;
            gap_cnt <= 2'h0;
        end else begin
            // Held off so the bench can watch the lockout
            cpu_instr_done <= run && !cpu_instr_done;
            cpu_nmi_ack <= cpu_nmi && !cpu_nmi_ack;
            cpu_ack <= 1'b0;
            if (busy) begin
                busy <= !cpu_ack_valid;
            end else if (cpu_irq && ack_en) begin
                // A slow core lets the request wait
                gap_cnt <= gap_cnt + 2'h1;
                if (gap_cnt == ack_gap) begin
                    cpu_ack <= 1'b1;
                    busy <= 1'b1;
                    gap_cnt <= 2'h0;
                end
            end
        end
    end
endmodule // irc_cpu_model
`default_nettype wire

// File: testbench/irc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "irc_map.vh"
module irc_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin and core side
    input wire logic nmi_n,
    input wire logic cpu_instr_done,
    input wire logic cpu_ack,
    input wire logic cpu_irq,
    input wire logic cpu_nmi,
    input wire logic cpu_ack_valid,
    input wire logic cpu_halt,
    input wire logic cpu_clk_run,
    input wire logic stop_clocks,
    input wire logic [15:0] user_stack_pointer,
    input wire logic [15:0] interrupt_stack_pointer
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // Lockout tracking
    // ****************************************
    logic seen_instr;
    always @(posedge aclk) begin
        if (!aresetn) begin
            seen_instr <= 1'b0;
        end else if (cpu_instr_done) begin
            seen_instr <= 1'b1;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    chk_ack_answer: assert property (cpu_ack_valid == $past(cpu_ack))
        else $error("ack answer not one cycle after ack");
    chk_ack_drops_irq: assert property (cpu_ack |=> !cpu_irq)
        else $error("request still offered after ack");
    // Reset is the cause here, so it must not disable these two
    chk_sp_reset: assert property (disable iff (1'b0) !aresetn |=>
        (user_stack_pointer == `IRC_SP_RST && interrupt_stack_pointer == `IRC_SP_RST))
        else $error("stack pointers not cleared by reset");
    chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        (!cpu_irq && !cpu_nmi && cpu_clk_run && !stop_clocks))
        else $error("core outputs active after reset");
    chk_lockout_first: assert property (!seen_instr |-> !cpu_irq && !cpu_nmi)
        else $error("request offered before first instruction");
    chk_nmi_deliver: assert property (seen_instr && $fell(nmi_n) |-> ##[1:8] cpu_nmi)
        else $error("pin fall not delivered to core");
    chk_stop_nmi_low: assert property (!nmi_n [*6] |-> !stop_clocks)
        else $error("stop requested while pin low");
    chk_wait_clock: assert property (!cpu_clk_run |-> cpu_halt)
        else $error("clock stopped without halt");
    chk_nmi_wait: assert property (cpu_halt && !cpu_clk_run && $fell(nmi_n) |-> ##[1:8] (cpu_halt && cpu_clk_run))
        else $error("pin fall in wait did not restart clock");
    cov_ack: cover property (cpu_ack_valid);
    cov_nmi_halt: cover property (cpu_halt && cpu_clk_run);
    cov_stop: cover property (stop_clocks);
endmodule // irc_top_sva
bind irc_top irc_top_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .nmi_n(nmi_n), .cpu_instr_done(cpu_instr_done), .cpu_ack(cpu_ack),
    .cpu_irq(cpu_irq), .cpu_nmi(cpu_nmi), .cpu_ack_valid(cpu_ack_valid), .cpu_halt(cpu_halt),
    .cpu_clk_run(cpu_clk_run), .stop_clocks(stop_clocks), .user_stack_pointer(user_stack_pointer),
    .interrupt_stack_pointer(interrupt_stack_pointer)
);
`default_nettype wire
